/* hw/dmf_cfg_mem.sv */
// Configuration store for all instances, written one field at a time.
// Assumes one clock; read data appear one cycle after the read index.
`include "dmf_params.svh"

module dmf_cfg_mem (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_wr_en,
    input wire logic [3:0] i_wr_inst,
    input wire logic [3:0] i_wr_field,
    input wire logic i_wr_sel,
    input wire logic [31:0] i_wr_data,
    input wire logic [3:0] i_rd_inst,
    output dmf_pkg::dmf_cfg_s o_rd_data
);

    // Reset contents: undefined operation, identity, unit output scale.
    // Held as constants so the asynchronous reset loads fixed values only.
    localparam dmf_pkg::dmf_in_cfg_s rst_in = '{unary: dmf_pkg::dmf_unary_e'(`DMF_RST_UNARY),
        is_dflt: `DMF_RST_IS_DFLT, dflt: `DMF_RST_DFLT, scale: `DMF_RST_IN_SCALE,
        offset: `DMF_RST_IN_OFFSET};
    localparam dmf_pkg::dmf_cfg_s rst_cfg = '{op: dmf_pkg::dmf_op_e'(`DMF_RST_OP),
        out_scale: `DMF_RST_OUT_SCALE, out_offset: `DMF_RST_OUT_OFFSET, in: {rst_in, rst_in}};

    dmf_pkg::dmf_cfg_s cfg_q [`DMF_NUM_INST];
    dmf_pkg::dmf_cfg_s wr_old;
    dmf_pkg::dmf_cfg_s wr_new;
    logic wr_inst_ok;
    logic rd_inst_ok;

    assign wr_inst_ok = i_wr_inst < `DMF_NUM_INST;
    assign rd_inst_ok = i_rd_inst < `DMF_NUM_INST;
    assign wr_old = wr_inst_ok ? cfg_q[i_wr_inst] : rst_cfg;

    // Merge the written field into the addressed entry.
    always_comb
    begin
        wr_new = wr_old;
        unique case (i_wr_field)
            `DMF_FLD_OP:
            begin
                if (i_wr_data <= 32'(`DMF_OP_MAX))
                begin
                    wr_new.op = dmf_pkg::dmf_op_e'(i_wr_data[4:0]);
                end
            end
            `DMF_FLD_OUT_SCALE: wr_new.out_scale = i_wr_data;
            `DMF_FLD_OUT_OFFSET: wr_new.out_offset = i_wr_data;
            `DMF_FLD_UNARY:
            begin
                if (i_wr_data <= 32'h0000_0003)
                begin
                    wr_new.in[i_wr_sel].unary = dmf_pkg::dmf_unary_e'(i_wr_data[1:0]);
                end
            end
            `DMF_FLD_IN_SCALE: wr_new.in[i_wr_sel].scale = i_wr_data;
            `DMF_FLD_IN_OFFSET: wr_new.in[i_wr_sel].offset = i_wr_data;
            `DMF_FLD_IS_DFLT: wr_new.in[i_wr_sel].is_dflt = i_wr_data[0];
            `DMF_FLD_DFLT: wr_new.in[i_wr_sel].dflt = i_wr_data;
            default: wr_new = wr_old;
        endcase
    end

    // Storage with a registered read port.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int i = 0; i < `DMF_NUM_INST; i++)
            begin
                cfg_q[i] <= rst_cfg;
            end
            o_rd_data <= rst_cfg;
        end
        else
        begin
            if (i_wr_en && wr_inst_ok)
            begin
                cfg_q[i_wr_inst] <= wr_new;
            end
            o_rd_data <= rd_inst_ok ? cfg_q[i_rd_inst] : rst_cfg;
        end
    end

endmodule

/* hw/dmf_top.sv */
// Ten dual-input math function units sharing one arithmetic datapath.
// Assumes synchronous inputs, one clock, fixed-point Q16.16 signal values.
//
// Overview of operation
// - Ten instances, two inputs, one output each.
// - Output is scaled combination of scaled unaries.
// - Undefined input takes its enabled default.
// - Undefined input without default: output undefined.
// - Unary: identity, logical not, bitwise not, abs.
// - Logical and bitwise not use unsigned integer.
// - Operation code zero makes output undefined.
// - Add, subtract, multiply, maximum, minimum operations.
// - Comparisons eight to thirteen give one/zero.
// - Division; zero divisor returns zero.
// - Integer operations convert operands to unsigned first.
// - Operation selector zero to twenty, default zero.
// - Unary selector zero to three, default identity.
// - Output scale defaults one, offset zero.
`include "dmf_params.svh"

module dmf_top (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_update,
    input wire dmf_pkg::dmf_sig_s [`DMF_NUM_INST-1:0][1:0] i_in,
    input wire logic i_cfg_we,
    input wire logic [3:0] i_cfg_inst,
    input wire logic [3:0] i_cfg_field,
    input wire logic i_cfg_sel,
    input wire logic [31:0] i_cfg_data,
    output dmf_pkg::dmf_sig_s [`DMF_NUM_INST-1:0] o_out,
    output logic o_busy,
    output logic o_done
);

    // Integer part of a value as a 4-byte unsigned number, fraction dropped.
    function automatic logic [31:0] to_uint(input dmf_pkg::dmf_fix_t x);
        to_uint = {{`DMF_FRAC{x[31]}}, x[31:`DMF_FRAC]};
    endfunction

    // Integer back to a numeric value; bits above the integer field are lost.
    function automatic dmf_pkg::dmf_fix_t from_uint(input logic [31:0] u);
        from_uint = {u[15:0], 16'h0000};
    endfunction

    // Fixed-point product, truncated.
    function automatic dmf_pkg::dmf_fix_t fmul(input dmf_pkg::dmf_fix_t a,
                                               input dmf_pkg::dmf_fix_t b);
        logic signed [63:0] p;
        p = 64'(a) * 64'(b);
        fmul = p[47:16];
    endfunction

    // Selected unary function of one input.
    function automatic dmf_pkg::dmf_fix_t unary(input dmf_pkg::dmf_unary_e sel,
                                                input dmf_pkg::dmf_fix_t x);
        unique case (sel)
            dmf_pkg::DMF_UN_IDENT: unary = x;
            dmf_pkg::DMF_UN_LNOT: unary = from_uint({31'h0, to_uint(x) == 32'h0});
            dmf_pkg::DMF_UN_BNOT: unary = from_uint(~to_uint(x));
            dmf_pkg::DMF_UN_ABS: unary = x[31] ? -x : x;
        endcase
    endfunction

    // Scaled and offset result of one input stage.
    function automatic dmf_pkg::dmf_fix_t stage(input dmf_pkg::dmf_in_cfg_s c,
                                                input dmf_pkg::dmf_fix_t x);
        stage = fmul(c.scale, unary(c.unary, x)) + c.offset;
    endfunction

    logic [3:0] inst_q;
    logic [3:0] inst_d;
    dmf_pkg::dmf_state_e state_q;
    dmf_pkg::dmf_state_e state_d;
    dmf_pkg::dmf_sig_s [`DMF_NUM_INST-1:0][1:0] in_q;
    dmf_pkg::dmf_cfg_s cfg;
    dmf_pkg::dmf_sig_s [1:0] cur_in;
    dmf_pkg::dmf_fix_t [1:0] pick;
    logic [1:0] defined;
    dmf_pkg::dmf_fix_t x;
    dmf_pkg::dmf_fix_t y;
    logic [31:0] ux;
    logic [31:0] uy;
    logic signed [63:0] quot;
    dmf_pkg::dmf_fix_t f;
    dmf_pkg::dmf_fix_t one;
    dmf_pkg::dmf_fix_t zero;
    dmf_pkg::dmf_sig_s result;
    logic last_inst;

    // Configuration store, read at the instance being worked on.
    dmf_cfg_mem u_cfg_mem (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_wr_en(i_cfg_we),
        .i_wr_inst(i_cfg_inst),
        .i_wr_field(i_cfg_field),
        .i_wr_sel(i_cfg_sel),
        .i_wr_data(i_cfg_data),
        .i_rd_inst(inst_q),
        .o_rd_data(cfg)
    );

    // Input selection: live value, else enabled default, else undefined.
    assign cur_in = in_q[inst_q];
    for (genvar n = 0; n < 2; n++)
    begin : g_in
        assign pick[n] = cur_in[n].valid ? cur_in[n].value : cfg.in[n].dflt;
        assign defined[n] = cur_in[n].valid | cfg.in[n].is_dflt;
    end

    // Operands after unary, scale and offset.
    assign x = stage(cfg.in[0], pick[0]);
    assign y = stage(cfg.in[1], pick[1]);
    assign ux = to_uint(x);
    assign uy = to_uint(y);
    assign one = `DMF_FIX_ONE;
    assign zero = `DMF_FIX_ZERO;
    assign quot = (64'(x) <<< `DMF_FRAC) / ((y == zero) ? 64'sh1 : 64'(y));

    // Binary operation.
    always_comb
    begin
        f = zero;
        unique case (cfg.op)
            dmf_pkg::DMF_OP_UNDEF: f = zero;
            dmf_pkg::DMF_OP_ADD: f = x + y;
            dmf_pkg::DMF_OP_SUB: f = x - y;
            dmf_pkg::DMF_OP_MUL: f = fmul(x, y);
            dmf_pkg::DMF_OP_DIV: f = (y == zero) ? zero : quot[31:0];
            dmf_pkg::DMF_OP_MOD: f = (uy == 32'h0) ? zero : from_uint(ux % uy);
            dmf_pkg::DMF_OP_MAX: f = (x >= y) ? x : y;
            dmf_pkg::DMF_OP_MIN: f = (x <= y) ? x : y;
            dmf_pkg::DMF_OP_EQ: f = (x == y) ? one : zero;
            dmf_pkg::DMF_OP_NE: f = (x != y) ? one : zero;
            dmf_pkg::DMF_OP_GT: f = (x > y) ? one : zero;
            dmf_pkg::DMF_OP_GE: f = (x >= y) ? one : zero;
            dmf_pkg::DMF_OP_LT: f = (x < y) ? one : zero;
            dmf_pkg::DMF_OP_LE: f = (x <= y) ? one : zero;
            dmf_pkg::DMF_OP_LOR: f = ((ux != 32'h0) || (uy != 32'h0)) ? one : zero;
            dmf_pkg::DMF_OP_LAND: f = ((ux != 32'h0) && (uy != 32'h0)) ? one : zero;
            dmf_pkg::DMF_OP_BOR: f = from_uint(ux | uy);
            dmf_pkg::DMF_OP_BAND: f = from_uint(ux & uy);
            dmf_pkg::DMF_OP_BXOR: f = from_uint(ux ^ uy);
            dmf_pkg::DMF_OP_SHL:
                f = (uy >= `DMF_SHIFT_LIMIT) ? zero : from_uint(ux << uy[4:0]);
            dmf_pkg::DMF_OP_SHR:
                f = (uy >= `DMF_SHIFT_LIMIT) ? zero : from_uint(ux >> uy[4:0]);
            default: f = zero;
        endcase
    end

    // Output scaling and the defined flag that travels with it.
    assign result.value = fmul(cfg.out_scale, f) + cfg.out_offset;
    assign result.valid = (&defined) & (cfg.op != dmf_pkg::DMF_OP_UNDEF);

    // Sequencer: read the configuration, then compute, for each instance in turn.
    assign last_inst = inst_q == `DMF_LAST_INST;
    always_comb
    begin
        state_d = state_q;
        inst_d = inst_q;
        unique case (state_q)
            dmf_pkg::DMF_ST_IDLE:
            begin
                if (i_update)
                begin
                    state_d = dmf_pkg::DMF_ST_READ;
                    inst_d = 4'h0;
                end
            end
            dmf_pkg::DMF_ST_READ: state_d = dmf_pkg::DMF_ST_CALC;
            dmf_pkg::DMF_ST_CALC:
            begin
                state_d = last_inst ? dmf_pkg::DMF_ST_DONE : dmf_pkg::DMF_ST_READ;
                inst_d = last_inst ? inst_q : inst_q + 4'h1;
            end
            dmf_pkg::DMF_ST_DONE: state_d = dmf_pkg::DMF_ST_IDLE;
        endcase
    end

    // State, instance index and status flags.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= dmf_pkg::DMF_ST_IDLE;
            inst_q <= 4'h0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            inst_q <= inst_d;
            o_busy <= state_d != dmf_pkg::DMF_ST_IDLE;
            o_done <= state_d == dmf_pkg::DMF_ST_DONE;
        end
    end

    // Inputs are captured once per update so every instance sees one snapshot.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            in_q <= '0;
        end
        else if (state_q == dmf_pkg::DMF_ST_IDLE && i_update)
        begin
            in_q <= i_in;
        end
    end

    // Each output is rewritten once per update.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_out <= '0;
        end
        else if (state_q == dmf_pkg::DMF_ST_CALC)
        begin
            o_out[inst_q] <= result;
        end
    end

endmodule

/* shared/dmf_params.svh */
// Constants of the dual-input math function block: counts, formats, defaults, field codes.
// Assumes inclusion by bare name from the package and the design files.
`ifndef DMF_PARAMS_SVH
`define DMF_PARAMS_SVH

// Instance count and the index of the last instance.
`define DMF_NUM_INST 10
`define DMF_LAST_INST 4'h9
// Fixed-point value format: 32-bit signed, 16 fraction bits.
`define DMF_WIDTH 32
`define DMF_FRAC 16
`define DMF_FIX_ONE 32'h0001_0000
`define DMF_FIX_ZERO 32'h0000_0000
// Largest legal operation selector code.
`define DMF_OP_MAX 5'h14
// Reset values of the configuration fields.
`define DMF_RST_OP 5'h00
`define DMF_RST_UNARY 2'h0
`define DMF_RST_OUT_SCALE 32'h0001_0000
`define DMF_RST_OUT_OFFSET 32'h0000_0000
`define DMF_RST_IN_SCALE 32'h0000_0000
`define DMF_RST_IN_OFFSET 32'h0000_0000
`define DMF_RST_IS_DFLT 1'h0
`define DMF_RST_DFLT 32'h0000_0000
// Configuration field codes on the write port.
`define DMF_FLD_OP 4'h0
`define DMF_FLD_OUT_SCALE 4'h1
`define DMF_FLD_OUT_OFFSET 4'h2
`define DMF_FLD_UNARY 4'h3
`define DMF_FLD_IN_SCALE 4'h4
`define DMF_FLD_IN_OFFSET 4'h5
`define DMF_FLD_IS_DFLT 4'h6
`define DMF_FLD_DFLT 4'h7
// Shift amounts at or above this give zero.
`define DMF_SHIFT_LIMIT 32'h0000_0020

`endif

/* shared/dmf_pkg.sv */
// Types of the dual-input math function block.
// Assumes dmf_params.svh is on the include path.
`include "dmf_params.svh"

package dmf_pkg;

    // One fixed-point value.
    typedef logic signed [`DMF_WIDTH-1:0] dmf_fix_t;

    // A signal with its defined flag.
    typedef struct packed {
        logic valid;
        dmf_fix_t value;
    } dmf_sig_s;

    // Unary function choice.
    typedef enum logic [1:0] {
        DMF_UN_IDENT = 2'h0,
        DMF_UN_LNOT = 2'h1,
        DMF_UN_BNOT = 2'h2,
        DMF_UN_ABS = 2'h3
    } dmf_unary_e;

    // Binary operation choice.
    typedef enum logic [4:0] {
        DMF_OP_UNDEF = 5'h00, DMF_OP_ADD = 5'h01, DMF_OP_SUB = 5'h02,
        DMF_OP_MUL = 5'h03, DMF_OP_DIV = 5'h04, DMF_OP_MOD = 5'h05,
        DMF_OP_MAX = 5'h06, DMF_OP_MIN = 5'h07, DMF_OP_EQ = 5'h08,
        DMF_OP_NE = 5'h09, DMF_OP_GT = 5'h0a, DMF_OP_GE = 5'h0b,
        DMF_OP_LT = 5'h0c, DMF_OP_LE = 5'h0d, DMF_OP_LOR = 5'h0e,
        DMF_OP_LAND = 5'h0f, DMF_OP_BOR = 5'h10, DMF_OP_BAND = 5'h11,
        DMF_OP_BXOR = 5'h12, DMF_OP_SHL = 5'h13, DMF_OP_SHR = 5'h14
    } dmf_op_e;

    // Per-input configuration.
    typedef struct packed {
        dmf_unary_e unary;
        logic is_dflt;
        dmf_fix_t dflt;
        dmf_fix_t scale;
        dmf_fix_t offset;
    } dmf_in_cfg_s;

    // Per-instance configuration.
    typedef struct packed {
        dmf_op_e op;
        dmf_fix_t out_scale;
        dmf_fix_t out_offset;
        dmf_in_cfg_s [1:0] in;
    } dmf_cfg_s;

    // Sequencer states.
    typedef enum logic [1:0] {
        DMF_ST_IDLE = 2'h0,
        DMF_ST_READ = 2'h1,
        DMF_ST_CALC = 2'h2,
        DMF_ST_DONE = 2'h3
    } dmf_state_e;

endpackage

/* tb/dmf_src_model.sv */
// Model of the blocks that feed the math units: holds both inputs of every instance.
// Assumes one input is loaded per write, synchronous to the core clock.
`include "dmf_params.svh"

module dmf_src_model (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_set,
    input wire logic [3:0] i_inst,
    input wire logic i_sel,
    input wire dmf_pkg::dmf_sig_s i_sig,
    output dmf_pkg::dmf_sig_s [`DMF_NUM_INST-1:0][1:0] o_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // An undefined source flips its value every cycle, so stale data can never match.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            o_in <= '0;
        else
            for (int k = 0; k < `DMF_NUM_INST; k++)
                for (int n = 0; n < 2; n++)
                    if (i_set && i_inst == 4'(k) && i_sel == 1'(n))
                        o_in[k][n] <= i_sig;
                    else if (!o_in[k][n].valid)
                        o_in[k][n].value <= ~o_in[k][n].value;
    end
endmodule

/* tb/dmf_top_sva.sv */
// Timing and validity checks on the ports of the math function top.
// Assumes one clock and the asynchronous active-high reset.
`include "dmf_params.svh"

module dmf_top_sva (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_update,
    input wire dmf_pkg::dmf_sig_s [`DMF_NUM_INST-1:0][1:0] i_in,
    input wire logic i_cfg_we,
    input wire logic [3:0] i_cfg_inst,
    input wire logic [3:0] i_cfg_field,
    input wire logic i_cfg_sel,
    input wire logic [31:0] i_cfg_data,
    input wire dmf_pkg::dmf_sig_s [`DMF_NUM_INST-1:0] o_out,
    input wire logic o_busy,
    input wire logic o_done
);
    timeunit 1ns;
    timeprecision 1ps;

    logic dflt0_q;
    logic opz0_q;
    wire cfg0 = i_cfg_we && i_cfg_inst == 4'h0;

    // Tracks default enable of input zero and a zero operation of instance zero.
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            dflt0_q <= 1'b0;
            opz0_q <= 1'b1;
        end
        else if (cfg0 && i_cfg_field == `DMF_FLD_IS_DFLT && !i_cfg_sel)
            dflt0_q <= i_cfg_data[0];
        else if (cfg0 && i_cfg_field == `DMF_FLD_OP && i_cfg_data <= 32'h0000_0014)
            opz0_q <= i_cfg_data == 32'h0000_0000;
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    // An update accepted while idle.
    sequence s_taken;
        i_update && !o_busy;
    endsequence

    a_done_timing: assert property (s_taken |-> ##21 o_done)
        else $error("done pulse not at its fixed distance");
    a_busy_hold: assert property (s_taken |=> o_busy [*8])
        else $error("busy dropped early");
    a_busy_end: assert property ($fell(o_busy) |-> $past(o_done))
        else $error("busy fell without done");
    a_done_single: assert property (o_done |=> !o_done)
        else $error("done wider than one cycle");
    a_idle_steady: assert property (!o_busy |=> $stable(o_out))
        else $error("output changed while idle");
    a_last_wait: assert property (s_taken |-> ##3 $stable(o_out[9]) [*8])
        else $error("last instance written too soon");
    a_undef_input: assert property (
        s_taken ##0 (!i_in[0][0].valid && !dflt0_q) |-> ##3 !o_out[0].valid)
        else $error("undefined input gave defined output");
    a_op_zero: assert property (s_taken ##0 opz0_q |-> ##3 !o_out[0].valid)
        else $error("operation zero gave defined output");
endmodule

/* tb/dmf_top_tb.sv */
// Self-checking bench for the ten-unit math function top.
// Assumes the source model feeds all inputs and config goes through the write port.
`include "dmf_params.svh"

module dmf_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] ONE = 32'h0001_0000;
    // Expected results of ops 1..20 on 3.0 and 2.0, in halves.
    localparam int HALF [20] = '{10, 2, 12, 3, 2, 6, 4, 0, 2, 2, 2, 0, 0, 2, 2, 6, 4, 2, 24, 0};
    localparam logic [32:0] E3 [10] = '{33'h0, 33'h1_fffd_0000, 33'h1_0005_0000, 33'h1_0000_0000,
        33'h1_0009_0000, 33'h1_0012_0000, 33'h1_0005_0000, 33'h0, 33'h1_000c_0000, 33'h1_0000_0000};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic upd = 1'b0;
    logic cfg_we = 1'b0;
    logic [3:0] cfg_inst = 4'h0;
    logic [3:0] cfg_field = 4'h0;
    logic cfg_sel = 1'b0;
    logic [31:0] cfg_data = 32'h0;
    logic src_set = 1'b0;
    logic [3:0] src_inst = 4'h0;
    logic src_sel = 1'b0;
    dmf_pkg::dmf_sig_s src_sig = '0;
    dmf_pkg::dmf_sig_s [`DMF_NUM_INST-1:0][1:0] in_bus;
    dmf_pkg::dmf_sig_s [`DMF_NUM_INST-1:0] out_bus;
    logic busy;
    logic done;
    int err_count = 0;
    int total_checks = 0;

    dmf_src_model src (.i_core_clk(clk), .i_rst(rst), .i_set(src_set), .i_inst(src_inst),
        .i_sel(src_sel), .i_sig(src_sig), .o_in(in_bus));
    dmf_top uut (.i_core_clk(clk), .i_rst(rst), .i_update(upd), .i_in(in_bus),
        .i_cfg_we(cfg_we), .i_cfg_inst(cfg_inst), .i_cfg_field(cfg_field), .i_cfg_sel(cfg_sel),
        .i_cfg_data(cfg_data), .o_out(out_bus), .o_busy(busy), .o_done(done));

    // Clock at 25 MHz.
    initial
    begin
        forever #20 clk = ~clk;
    end

    task automatic close_out();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cfg(input logic [3:0] k, input logic [3:0] f, input logic s,
        input logic [31:0] d);
        @(posedge clk);
        cfg_we <= 1'b1;
        cfg_inst <= k;
        cfg_field <= f;
        cfg_sel <= s;
        cfg_data <= d;
        @(posedge clk);
        cfg_we <= 1'b0;
    endtask

    task automatic src_put(input logic [3:0] k, input logic s, input dmf_pkg::dmf_sig_s v);
        @(posedge clk);
        src_set <= 1'b1;
        src_inst <= k;
        src_sel <= s;
        src_sig <= v;
        @(posedge clk);
        src_set <= 1'b0;
    endtask

    // Starts an update, retries while busy (must be ignored), waits for done.
    task automatic run_update();
        int n = 0;
        @(posedge clk);
        upd <= 1'b1;
        @(posedge clk);
        upd <= 1'b0;
        repeat (3) @(posedge clk);
        upd <= 1'b1;
        @(posedge clk);
        upd <= 1'b0;
        while (done !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 40)
        begin
            err_count++;
            close_out();
        end
        @(posedge clk);
        @(negedge clk);
        chk({32'h0, busy}, 33'h0);
    endtask

    // Main sequence.
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({31'h0, busy, done}, 33'h0);
        for (int k = 0; k < 10; k++)
            for (int n = 0; n < 2; n++)
                src_put(4'(k), 1'(n), {1'b1, n ? 32'h0002_0000 : 32'h0003_0000});
        run_update();
        for (int k = 0; k < 10; k++)
            chk(out_bus[k], 33'h0);
        for (int k = 0; k < 10; k++)
        begin
            cfg(4'(k), `DMF_FLD_IN_SCALE, 1'b0, ONE);
            cfg(4'(k), `DMF_FLD_IN_SCALE, 1'b1, ONE);
            cfg(4'(k), `DMF_FLD_OP, 1'b0, 32'(k + 1));
        end
        run_update();
        for (int k = 0; k < 10; k++)
            chk(out_bus[k], {1'b1, 32'(HALF[k] <<< 15)});
        for (int k = 0; k < 10; k++)
            cfg(4'(k), `DMF_FLD_OP, 1'b0, 32'(k + 11));
        run_update();
        for (int k = 0; k < 10; k++)
            chk(out_bus[k], {1'b1, 32'(HALF[k + 10] <<< 15)});
        src_put(4'h0, 1'b0, {1'b0, 32'h0003_0000});
        src_put(4'h2, 1'b0, {1'b1, 32'hfffd_0000});
        src_put(4'h3, 1'b1, {1'b1, 32'h0});
        src_put(4'h4, 1'b0, {1'b0, 32'h0003_0000});
        cfg(4'h0, `DMF_FLD_OP, 1'b0, 32'h1);
        cfg(4'h1, `DMF_FLD_OP, 1'b0, 32'h1);
        cfg(4'h1, `DMF_FLD_UNARY, 1'b0, 32'h1);
        cfg(4'h1, `DMF_FLD_UNARY, 1'b1, 32'h2);
        cfg(4'h2, `DMF_FLD_OP, 1'b0, 32'h1);
        cfg(4'h2, `DMF_FLD_UNARY, 1'b0, 32'h3);
        cfg(4'h3, `DMF_FLD_OP, 1'b0, 32'h4);
        cfg(4'h4, `DMF_FLD_OP, 1'b0, 32'h1);
        cfg(4'h4, `DMF_FLD_IS_DFLT, 1'b0, 32'h1);
        cfg(4'h4, `DMF_FLD_DFLT, 1'b0, 32'h0007_0000);
        cfg(4'h5, `DMF_FLD_OP, 1'b0, 32'h1);
        cfg(4'h5, `DMF_FLD_OUT_SCALE, 1'b0, 32'h0002_0000);
        cfg(4'h5, `DMF_FLD_OUT_OFFSET, 1'b0, ONE);
        cfg(4'h5, `DMF_FLD_IN_SCALE, 1'b0, 32'h0002_0000);
        cfg(4'h5, `DMF_FLD_IN_OFFSET, 1'b0, 32'h0000_8000);
        cfg(4'h6, `DMF_FLD_OP, 1'b0, 32'h1);
        cfg(4'h6, `DMF_FLD_OP, 1'b0, 32'h15);
        cfg(4'h6, `DMF_FLD_UNARY, 1'b0, 32'h4);
        cfg(4'h7, `DMF_FLD_OP, 1'b0, 32'h0);
        cfg(4'h8, 4'h8, 1'b0, 32'h1);
        run_update();
        for (int k = 0; k < 10; k++)
            if (E3[k][32])
                chk(out_bus[k], E3[k]);
            else
                chk({32'h0, out_bus[k].valid}, 33'h0);
        close_out();
    end
endmodule

bind dmf_top dmf_top_sva u_sva (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_update(i_update),
    .i_in(i_in), .i_cfg_we(i_cfg_we), .i_cfg_inst(i_cfg_inst), .i_cfg_field(i_cfg_field),
    .i_cfg_sel(i_cfg_sel), .i_cfg_data(i_cfg_data), .o_out(o_out), .o_busy(o_busy),
    .o_done(o_done));
